//--- rtl/obs_pkg.sv
// Purpose: Shared constants and carriers for the core debug observation bus
// Assumes: One core clock, synchronous active-low reset
// Notes:   Bus bit positions are the absolute positions of the debug vector
//
// Function
// [R1] Bits 37:14 carry completion requester ID when header-second-half and pulse.
// [R2] On header-first-half with pulse, top eight bits carry format and type.
// [R3] Bit 38 is the receive pulse; bits 37:0 meaningful only then.
// [R4] Bit 39 mirrors the global transmit request to the link layer.
// [R5] Bit 40 mirrors the link layer acknowledge of that request.
// [R6] Bit 41 mirrors the link layer request for next packet data.
// [R7] Bit 42 set when the packet in flight is to be nullified.
// [R8] Bits 50:43 carry the channel arbitration grant of the packet.
// [R9] Bit 51 is the transmit pulse; cadence follows lane count.
// [R10] Bits 55:52 carry the legacy power scheduler state code.
// [R11] Bit 56 flags wake message sent, endpoint mode only.
// [R12] Bit 57 flags wake message resent after timeout, endpoint only.
// [R13] Bit 58 flags transmission inhibited before low-power entry.
// [R14] Bits 62:59 carry power requests: L0 exit, L0s, L1, L2.
// [R15] Bits 64:63 carry power events: exit detected, entry complete.
// [R16] Bit 65 flags received wake message dropped, root port only.
// [R17] Bit 66 shows link up from training state machine.
// [R18] Bit 67 shows data link up from link control.
// [R19] Bits 74:68 show enabled channels one to seven.
// [R20] Bits 82:75 show per-channel initialization done.
// [R21] Bits 84:83 show receiver port error and training error.
// [R22] Reception state: bit0 header first half, bit1 second, bit2 payload.
// [R23] Bus sampled every cycle and held at zero in reset. Code holds the bus while freeze is set and zeroes it while blank is set.
package obs_pkg;

  // ---------------------------------------------------------------
  // Observation bus layout
  // ---------------------------------------------------------------
  localparam int OBS_LO         = 14;
  localparam int OBS_HI         = 84;
  localparam int REQID_LO       = 14;
  localparam int REQID_HI       = 37;
  localparam int REQID_W        = 24;
  localparam int FMT_W          = 8;
  localparam int RX_OK_BIT      = 38;
  localparam int TX_REQ_BIT     = 39;
  localparam int TX_ACK_BIT     = 40;
  localparam int TX_DREQ_BIT    = 41;
  localparam int TX_NULL_BIT    = 42;
  localparam int GRANT_LO       = 43;
  localparam int GRANT_HI       = 50;
  localparam int TX_OK_BIT      = 51;
  localparam int LPS_LO         = 52;
  localparam int LPS_HI         = 55;
  localparam int WAKE_SENT_BIT  = 56;
  localparam int WAKE_RESNT_BIT = 57;
  localparam int INHIBIT_BIT    = 58;
  localparam int PMREQ_LO       = 59;
  localparam int PMREQ_HI       = 62;
  localparam int PMEVT_LO       = 63;
  localparam int PMEVT_HI       = 64;
  localparam int WAKE_DROP_BIT  = 65;
  localparam int LINK_UP_BIT    = 66;
  localparam int DATALINK_ACTIVE_BIT      = 67;
  localparam int CHEN_LO        = 68;
  localparam int CHEN_HI        = 74;
  localparam int CHDONE_LO      = 75;
  localparam int CHDONE_HI      = 82;
  localparam int PHYERR_LO      = 83;
  localparam int PHYERR_HI      = 84;

  // Reception state qualifiers
  localparam int RXST_HDR01 = 0;
  localparam int RXST_HDR23 = 1;
  localparam int RXST_DATA  = 2;

  // Legacy power scheduler codes
  typedef enum logic [3:0] {
    LPS_L0_RST   = 4'h0,
    LPS_L0       = 4'h1,
    LPS_L1_IN0   = 4'h2,
    LPS_L1_IN1   = 4'h3,
    LPS_L0_IN    = 4'h4,
    LPS_L0_IN_WT = 4'h5,
    LPS_L23_IN0  = 4'h6,
    LPS_L23_IN1  = 4'h7,
    LPS_L23_RDY  = 4'h8
  } legacy_power_state_t;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          AXI_AW     = 8;
  localparam int          CNT_W      = 16;
  localparam int          STICKY_W   = 5;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_OBS0   = 8'h04;
  localparam logic [7:0]  OFS_OBS1   = 8'h08;
  localparam logic [7:0]  OFS_OBS2   = 8'h0C;
  localparam logic [7:0]  OFS_RXCNT  = 8'h10;
  localparam logic [7:0]  OFS_TXCNT  = 8'h14;
  localparam logic [7:0]  OFS_STICKY = 8'h18;
  localparam logic [7:0]  OFS_PWR    = 8'h1C;
  localparam logic [7:0]  OFS_HDR    = 8'h20;
  localparam int          CTRL_FREEZE = 0;
  localparam int          CTRL_BLANK  = 1;
  localparam logic [1:0]  CTRL_RST    = 2'h0;
  localparam int          STK_RXPORT  = 0;
  localparam int          STK_TRAIN   = 1;
  localparam int          STK_DROP    = 2;
  localparam int          STK_NULL    = 3;
  localparam int          STK_RSVD    = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  rx_state;
    logic        rx_ok;
    logic [23:0] rx_reqid;
    logic [7:0]  rx_fmt_type;
    logic        tx_req;
    logic        tx_ack;
    logic        tx_dreq;
    logic        tx_nullify;
    logic [7:0]  tx_channel_grant;
    logic        tx_ok;
    logic [3:0]  legacy_power_state;
    logic        wake_sent;
    logic        wake_resent;
    logic        tx_inhibit;
    logic [3:0]  pm_request;
    logic [1:0]  pm_event;
    logic        wake_message_dropped;
    logic        link_up;
    logic        datalink_active;
    logic [6:0]  channel_enable_mask;
    logic [7:0]  channel_init_done;
    logic [1:0]  phy_error;
  } core_obs_t;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic              awvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [AXI_AW-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axil_rsp_t;

  typedef struct packed {
    logic              aw_held;
    logic              w_held;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    axil_rsp_t         rsp;
  } axil_state_t;

  typedef struct packed {
    logic [OBS_HI:OBS_LO] obs;
    logic [1:0]           ctrl;
    logic [REQID_W-1:0]   hdr;
    logic [CNT_W-1:0]     rx_cnt;
    logic [CNT_W-1:0]     tx_cnt;
  } obs_state_t;

endpackage

//--- rtl/sticky_flags.sv
// Purpose: Sticky event flags with write-one-to-clear
// Assumes: Set and clear are one-cycle strobes in the core clock
// Notes:   A set in the clear cycle survives
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags
);

  logic [W-1:0] next_flags;

  // Set wins so no event is lost to a racing clear
  always_comb begin
    next_flags = (flags & ~clr) | set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

endmodule
`default_nettype wire

//--- rtl/axil_slave.sv
// Purpose: AXI4-Lite slave front end with one write and one read in flight
// Assumes: Register file answers read data and decode errors combinationally
// Notes:   Address and data channels are taken in either order
`timescale 1ns/1ps
`default_nettype none
module axil_slave
  import obs_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire axil_req_t         req,
  output axil_rsp_t              rsp,
  output logic                   wr_fire,
  output logic [AXI_AW-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_err,
  output logic [AXI_AW-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_err
);

  axil_state_t s;
  axil_state_t next_s;

  // Register strobes come from held channel flops
  assign wr_fire = s.aw_held & s.w_held & ~s.rsp.bvalid;
  assign wr_addr = s.awaddr;
  assign wr_data = s.wdata;
  assign wr_strb = s.wstrb;
  assign rd_addr = req.araddr;
  assign rsp     = s.rsp;

  // Channel capture, response and ready generation
  always_comb begin
    next_s = s;
    if (req.awvalid && s.rsp.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr  = req.awaddr;
    end
    if (req.wvalid && s.rsp.wready) begin
      next_s.w_held = 1'b1;
      next_s.wdata  = req.wdata;
      next_s.wstrb  = req.wstrb;
    end
    if (wr_fire) begin
      next_s.aw_held   = 1'b0;
      next_s.w_held    = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s.rsp.bvalid && req.bready) begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (req.arvalid && s.rsp.arready) begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata  = rd_data;
      next_s.rsp.rresp  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s.rsp.rvalid && req.rready) begin
      next_s.rsp.rvalid = 1'b0;
    end
    // Ready is registered from the next state, so it opens on the same edge a channel frees
    next_s.rsp.awready = ~next_s.aw_held & ~next_s.rsp.bvalid;
    next_s.rsp.wready  = ~next_s.w_held & ~next_s.rsp.bvalid;
    next_s.rsp.arready = ~next_s.rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

//--- rtl/pcie_core_debug_observe_bus.sv
// Purpose: Debug observation slice, bits 84:14, of the core test vector
// Assumes: Core status inputs are synchronous to aclk
// Notes:   Every bus bit is a register, so all fields show one cycle late
`timescale 1ns/1ps
`default_nettype none
module pcie_core_debug_observe_bus
  import obs_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire core_obs_t             core,
  input  wire logic                  root_port_mode,
  input  wire axil_req_t             axil_req,
  output axil_rsp_t                  axil_rsp,
  output logic [OBS_HI:OBS_LO]       observe_bus
);

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------

  // Word address match, low two bits ignored
  function automatic logic hit(input logic [AXI_AW-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a[AXI_AW-1:2] == ofs[AXI_AW-1:2]);
  endfunction

  // Known register address
  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = hit(a, OFS_CTRL)  | hit(a, OFS_OBS0)   | hit(a, OFS_OBS1) |
             hit(a, OFS_OBS2)  | hit(a, OFS_RXCNT)  | hit(a, OFS_TXCNT) |
             hit(a, OFS_STICKY) | hit(a, OFS_PWR)   | hit(a, OFS_HDR);
  endfunction

  // Codes past the last scheduler state are reserved
  function automatic logic lps_reserved(input logic [3:0] code);
    lps_reserved = (code > LPS_L23_RDY);
  endfunction

  // ---------------------------------------------------------------
  // State and bus slave
  // ---------------------------------------------------------------
  obs_state_t            s;
  obs_state_t            next_s;
  logic                  wr_fire;
  logic [AXI_AW-1:0]     wr_addr;
  logic [31:0]           wr_data;
  logic [3:0]            wr_strb;
  logic [AXI_AW-1:0]     rd_addr;
  logic [31:0]           rd_data;
  logic                  rd_err;
  logic                  wr_err;
  logic [STICKY_W-1:0]   stk_set;
  logic [STICKY_W-1:0]   stk_clr;
  logic [STICKY_W-1:0]   stk;
  logic [OBS_HI:OBS_LO]  live;
  logic [REQID_W-1:0]    next_hdr;
  logic                  endpoint;

  axil_slave u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (axil_req),
    .rsp     (axil_rsp),
    .wr_fire (wr_fire),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  sticky_flags #(
    .W (STICKY_W)
  ) u_sticky (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (stk_set),
    .clr     (stk_clr),
    .flags   (stk)
  );

  assign endpoint = ~root_port_mode;
  assign wr_err   = ~mapped(wr_addr);
  assign observe_bus = s.obs;

  // ---------------------------------------------------------------
  // Receive header field
  // ---------------------------------------------------------------

  // Held between pulses so the field never shows a half-formed header
  always_comb begin
    next_hdr = s.hdr;
    if (core.rx_ok && core.rx_state[RXST_HDR23]) begin
      next_hdr = core.rx_reqid; // [R1] [R22]
    end
    // Header first half outranks if both halves arrive together
    if (core.rx_ok && core.rx_state[RXST_HDR01]) begin
      next_hdr[REQID_W-1 -: FMT_W] = core.rx_fmt_type; // [R2] [R22]
    end
  end

  // ---------------------------------------------------------------
  // Live field packing
  // ---------------------------------------------------------------

  // Mirrors of receive header, transmit handshakes, power management and link status
  always_comb begin
    live = '0;
    live[REQID_HI:REQID_LO]   = next_hdr; // [R1] [R2]
    live[RX_OK_BIT]           = core.rx_ok; // [R3]
    live[TX_REQ_BIT]          = core.tx_req; // [R4]
    live[TX_ACK_BIT]          = core.tx_ack; // [R5]
    live[TX_DREQ_BIT]         = core.tx_dreq; // [R6]
    live[TX_NULL_BIT]         = core.tx_nullify; // [R7]
    live[GRANT_HI:GRANT_LO]   = core.tx_channel_grant; // [R8]
    live[TX_OK_BIT]           = core.tx_ok; // [R9]
    live[LPS_HI:LPS_LO]       = core.legacy_power_state; // [R10]
    live[WAKE_SENT_BIT]       = core.wake_sent & endpoint; // [R11]
    live[WAKE_RESNT_BIT]      = core.wake_resent & endpoint; // [R12]
    live[INHIBIT_BIT]         = core.tx_inhibit; // [R13]
    live[PMREQ_HI:PMREQ_LO]   = core.pm_request; // [R14]
    live[PMEVT_HI:PMEVT_LO]   = core.pm_event; // [R15]
    live[WAKE_DROP_BIT]       = core.wake_message_dropped &
                                root_port_mode; // [R16]
    live[LINK_UP_BIT]         = core.link_up; // [R17]
    live[DATALINK_ACTIVE_BIT]           = core.datalink_active; // [R18]
    live[CHEN_HI:CHEN_LO]     = core.channel_enable_mask; // [R19]
    live[CHDONE_HI:CHDONE_LO] = core.channel_init_done; // [R20]
    live[PHYERR_HI:PHYERR_LO] = core.phy_error; // [R21]
  end

  // ---------------------------------------------------------------
  // Sticky event capture
  // ---------------------------------------------------------------

  // Short error pulses are easy to miss on a free-running capture
  always_comb begin
    stk_set = '0;
    stk_set[STK_RXPORT] = core.phy_error[0];
    stk_set[STK_TRAIN]  = core.phy_error[1];
    stk_set[STK_DROP]   = core.wake_message_dropped & root_port_mode;
    stk_set[STK_NULL]   = core.tx_nullify;
    stk_set[STK_RSVD]   = lps_reserved(core.legacy_power_state);
    stk_clr = '0;
    if (wr_fire && hit(wr_addr, OFS_STICKY) && wr_strb[0]) begin
      stk_clr = wr_data[STICKY_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Register read mux
  // ---------------------------------------------------------------

  // Unmapped reads return zero with an error response
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (hit(rd_addr, OFS_CTRL)) begin
      rd_data[1:0] = s.ctrl;
    end else if (hit(rd_addr, OFS_OBS0)) begin
      rd_data = s.obs[OBS_LO+31:OBS_LO];
    end else if (hit(rd_addr, OFS_OBS1)) begin
      rd_data = s.obs[OBS_LO+63:OBS_LO+32];
    end else if (hit(rd_addr, OFS_OBS2)) begin
      rd_data[OBS_HI-OBS_LO-64:0] = s.obs[OBS_HI:OBS_LO+64];
    end else if (hit(rd_addr, OFS_RXCNT)) begin
      rd_data[CNT_W-1:0] = s.rx_cnt;
    end else if (hit(rd_addr, OFS_TXCNT)) begin
      rd_data[CNT_W-1:0] = s.tx_cnt;
    end else if (hit(rd_addr, OFS_STICKY)) begin
      rd_data[STICKY_W-1:0] = stk;
    end else if (hit(rd_addr, OFS_PWR)) begin
      rd_data[3:0]  = s.obs[LPS_HI:LPS_LO];
      rd_data[4]    = lps_reserved(s.obs[LPS_HI:LPS_LO]);
      rd_data[8:5]  = s.obs[PMREQ_HI:PMREQ_LO];
      rd_data[10:9] = s.obs[PMEVT_HI:PMEVT_LO];
    end else if (hit(rd_addr, OFS_HDR)) begin
      rd_data[REQID_W-1:0] = s.hdr;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Freeze holds the last view for a slow reader; blank forces zero
  always_comb begin
    next_s = s;
    next_s.hdr = next_hdr;
    if (s.ctrl[CTRL_BLANK]) begin
      next_s.obs = '0;
    end else if (!s.ctrl[CTRL_FREEZE]) begin
      next_s.obs = live; // [R23]
    end
    // Pulse counters wrap; they give a rate, not a total
    if (core.rx_ok) begin
      next_s.rx_cnt = s.rx_cnt + 1'b1; // [R3]
    end
    if (core.tx_ok) begin
      next_s.tx_cnt = s.tx_cnt + 1'b1; // [R9]
    end
    if (wr_fire && hit(wr_addr, OFS_CTRL) && wr_strb[0]) begin
      next_s.ctrl = wr_data[1:0];
    end
  end

  // Synchronous reset zeroes the whole view
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s      <= '0; // [R23]
      s.ctrl <= CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

//--- testbench/capture_probe.sv
// Purpose: Debug capture logic watching the observation bus
// Assumes: Same core clock as the bus
// Notes:   Keeps only the last requester field seen with a pulse
`timescale 1ns/1ps
`default_nettype none
module capture_probe
  import obs_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [OBS_HI:OBS_LO] observe_bus,
  output logic      [REQID_W-1:0]   cap_reqid
);
  // Field is meaningful only in pulse cycles, so latch only then
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_reqid <= '0;
    end else if (observe_bus[RX_OK_BIT]) begin
      cap_reqid <= observe_bus[REQID_HI:REQID_LO];
    end
  end
endmodule
`default_nettype wire

//--- testbench/obs_bus_chk.sv
// Purpose: Concurrent checks on the observation bus
// Assumes: Only the top-level ports are visible
// Notes:   Control shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none
module obs_bus_chk
  import obs_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire core_obs_t            core,
  input wire logic                 root_port_mode,
  input wire axil_req_t            axil_req,
  input wire axil_rsp_t            axil_rsp,
  input wire logic [OBS_HI:OBS_LO] observe_bus
);
  // ----------------
  // Shadow of the control register
  // ----------------
  logic [7:0] wa;
  logic [2:0] wd;
  logic [1:0] ctl;
  logic [1:0] up;
  logic       bv_d;
  logic       live;
  // Lags ctrl one edge, as the bus does
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {wa, wd, ctl, up, bv_d} <= '0;
    end else begin
      up   <= {up[0], 1'b1};
      bv_d <= axil_rsp.bvalid;
      if (axil_req.awvalid && axil_rsp.awready) begin
        wa <= axil_req.awaddr;
      end
      if (axil_req.wvalid && axil_rsp.wready) begin
        wd <= {axil_req.wstrb[0], axil_req.wdata[1:0]};
      end
      if (axil_rsp.bvalid && !bv_d && wa[7:2] == OFS_CTRL[7:2] && wd[2]) begin
        ctl <= wd[1:0];
      end
    end
  end
  // Skip two edges after reset
  assign live = up[1] && (ctl == 2'b00);
  // ----------------
  // Assertions
  // ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RX_PULSE: assert property (
    live |-> observe_bus[38] == $past(core.rx_ok))
    else $error("rx pulse");
  AST_REQID: assert property (
    live && $past(core.rx_ok && core.rx_state[1:0] == 2'b10)
    |-> observe_bus[37:14] == $past(core.rx_reqid))
    else $error("reqid");
  AST_FMT: assert property (
    live && $past(core.rx_ok && core.rx_state[0])
    |-> observe_bus[37:30] == $past(core.rx_fmt_type))
    else $error("fmt type");
  AST_HOLD: assert property (
    live && $past(live) && !$past(core.rx_ok)
    |-> $stable(observe_bus[37:14]))
    else $error("reqid moved");
  AST_TX_HS: assert property (
    live |-> observe_bus[42:39] == $past({core.tx_nullify,
      core.tx_dreq, core.tx_ack, core.tx_req}))
    else $error("tx handshake");
  AST_GRANT: assert property (
    live |-> observe_bus[51:43] == $past({core.tx_ok,
      core.tx_channel_grant}))
    else $error("grant");
  AST_POWER: assert property (
    live |-> observe_bus[64:58] == $past({core.pm_event,
      core.pm_request, core.tx_inhibit}) &&
    observe_bus[55:52] == $past(core.legacy_power_state))
    else $error("power");
  AST_WAKE: assert property (
    live |-> observe_bus[57:56] == ($past(root_port_mode) ? 2'b00 :
      $past({core.wake_resent, core.wake_sent})) &&
    observe_bus[65] == $past(root_port_mode && core.wake_message_dropped))
    else $error("wake flags");
  AST_LINK: assert property (
    live |-> observe_bus[84:66] == $past({core.phy_error,
      core.channel_init_done, core.channel_enable_mask,
      core.datalink_active, core.link_up}))
    else $error("link fields");
  COV_REQID: cover property (live && $past(core.rx_ok && core.rx_state[1]));
  COV_BLANK: cover property (ctl[1]);
  COV_ERR: cover property (axil_rsp.bvalid && axil_rsp.bresp == RESP_SLVERR);
endmodule
bind pcie_core_debug_observe_bus obs_bus_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .core(core),
  .root_port_mode(root_port_mode), .axil_req(axil_req),
  .axil_rsp(axil_rsp), .observe_bus(observe_bus));
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the bus slice
// Assumes: Register port answers per its contract
// Notes:   Model rebuilds the bus every edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import obs_pkg::*;
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  core_obs_t            core = '0;
  logic                 root_port_mode = 1'b0;
  axil_req_t            axil_req = '0;
  axil_rsp_t            axil_rsp;
  logic [OBS_HI:OBS_LO] observe_bus, ebus, ebus_d, frz;
  logic [REQID_W-1:0]   hdr, cap_reqid;
  logic [15:0]          rx_n, tx_n;
  logic [4:0]           stk;
  logic [95:0]          rv;
  int                   seed = 32'hEC66;
  int                   failures = 0;
  int                   compares = 0;
  int                   cyc = 0;
  logic                 rnd = 1'b0;
  logic                 chk_on = 1'b0;
  always #2.5 aclk = ~aclk;
  pcie_core_debug_observe_bus i_dut (.aclk(aclk), .aresetn(aresetn),
    .core(core), .root_port_mode(root_port_mode), .axil_req(axil_req),
    .axil_rsp(axil_rsp), .observe_bus(observe_bus));
  capture_probe i_probe (.aclk(aclk), .aresetn(aresetn),
    .observe_bus(observe_bus), .cap_reqid(cap_reqid));
  // ----------------
  // Checking and closing
  // ----------------
  task automatic check(input string nm, input logic [127:0] seen,
                       input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Expected bus for one sample
  function automatic logic [OBS_HI:OBS_LO] f_bus(core_obs_t c, logic rp,
                                               logic [23:0] h);
    return {c.phy_error, c.channel_init_done, c.channel_enable_mask,
      c.datalink_active, c.link_up, c.wake_message_dropped & rp,
      c.pm_event, c.pm_request, c.tx_inhibit, c.wake_resent & !rp,
      c.wake_sent & !rp, c.legacy_power_state, c.tx_ok,
      c.tx_channel_grant, c.tx_nullify, c.tx_dreq, c.tx_ack, c.tx_req,
      c.rx_ok, h};
  endfunction
  // ----------------
  // Register port master
  // ----------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    @(posedge aclk);
    axil_req.awaddr  <= a;
    axil_req.awvalid <= 1'b1;
    axil_req.wdata   <= d;
    axil_req.wstrb   <= 4'hF;
    axil_req.wvalid  <= 1'b1;
    axil_req.bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
      if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
    end while (!axil_rsp.bvalid);
    axil_req.bready <= 1'b0;
    check("bresp", axil_rsp.bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    @(posedge aclk);
    axil_req.araddr  <= a;
    axil_req.arvalid <= 1'b1;
    axil_req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
    end while (!axil_rsp.rvalid);
    axil_req.rready <= 1'b0;
    check("rdata", axil_rsp.rdata, ed);
    check("rresp", axil_rsp.rresp, er);
  endtask
  // ----------------
  // Stimulus, model and monitor
  // ----------------
  // Random inputs
  always @(posedge aclk) begin
    if (rnd) begin
      rv = {$random(seed), $random(seed), $random(seed)};
      core <= core_obs_t'(rv[81:0]);
    end
  end
  // Model samples at the design's edge
  always @(posedge aclk) begin
    ebus_d = ebus;
    cyc++;
    if (!aresetn) begin
      {hdr, ebus, rx_n, tx_n, stk} = '0;
    end else begin
      if (core.rx_ok && core.rx_state[1]) hdr = core.rx_reqid;
      if (core.rx_ok && core.rx_state[0]) hdr[23:16] = core.rx_fmt_type;
      ebus = f_bus(core, root_port_mode, hdr);
      rx_n = rx_n + {15'h0, core.rx_ok};
      tx_n = tx_n + {15'h0, core.tx_ok};
      stk = stk | {core.legacy_power_state > 4'h8, core.tx_nullify,
        core.wake_message_dropped & root_port_mode, core.phy_error};
    end
    if (cyc == 5000) begin
      failures++;
      tally_and_finish;
    end
  end
  // Compare mid-cycle
  always @(negedge aclk) begin
    if (chk_on) begin
      check("rx", observe_bus[38:14], ebus[38:14]);
      check("tx", observe_bus[51:39], ebus[51:39]);
      check("pm", observe_bus[65:52], ebus[65:52]);
      check("ln", observe_bus[84:66], ebus[84:66]);
    end
  end
  initial begin
    core_obs_t c;
    repeat (11) @(posedge aclk);
    @(negedge aclk);
    check("reset bus", observe_bus, '0);
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axr(OFS_CTRL, 32'(CTRL_RST), RESP_OKAY);
    rnd <= 1'b1;
    repeat (3) @(posedge aclk);
    chk_on = 1'b1;
    repeat (300) @(posedge aclk);
    rnd <= 1'b0;
    // Pulses over every state and code
    for (int i = 0; i < 16; i++) begin
      @(posedge aclk);
      rv = {$random(seed), $random(seed), $random(seed)};
      c = core_obs_t'(rv[81:0]);
      c.rx_ok = 1'b1;
      c.rx_state = i[2:0];
      c.legacy_power_state = i[3:0];
      core <= c;
    end
    @(posedge aclk);
    rnd <= 1'b1;
    root_port_mode <= 1'b1;
    repeat (300) @(posedge aclk);
    chk_on = 1'b0;
    axw(OFS_CTRL, 32'h1, RESP_OKAY);
    @(negedge aclk);
    frz = ebus_d;
    repeat (8) @(negedge aclk);
    check("frozen bus", observe_bus, frz);
    axr(OFS_CTRL, 32'h1, RESP_OKAY);
    axw(OFS_CTRL, 32'h3, RESP_OKAY);
    repeat (2) @(negedge aclk);
    check("blank bus", observe_bus, '0);
    axw(OFS_CTRL, 32'h0, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_on = 1'b1;
    repeat (60) @(posedge aclk);
    rnd <= 1'b0;
    @(posedge aclk);
    core <= '0;
    repeat (3) @(posedge aclk);
    axr(OFS_RXCNT, {16'h0, rx_n}, RESP_OKAY);
    axr(OFS_TXCNT, {16'h0, tx_n}, RESP_OKAY);
    axr(OFS_STICKY, {27'h0, stk}, RESP_OKAY);
    axw(OFS_STICKY, 32'h1F, RESP_OKAY);
    axr(OFS_STICKY, 32'h0, RESP_OKAY);
    axr(OFS_HDR, {8'h0, hdr}, RESP_OKAY);
    axr(OFS_OBS0, ebus[45:14], RESP_OKAY);
    check("probe header", cap_reqid, hdr);
    axw(OFS_RXCNT, 32'h5, RESP_OKAY);
    axr(OFS_RXCNT, {16'h0, rx_n}, RESP_OKAY);
    axw(8'h40, 32'h1, RESP_SLVERR);
    axr(8'h40, 32'h0, RESP_SLVERR);
    tally_and_finish;
  end
endmodule
`default_nettype wire
